// ### bdr_board_glue.v
// Address decode, output holding registers, watchdog and reset glue for the board.
// Summary of operation
// - Eight 8 KB regions are selected by the top three address bits only.
// - Program-fetch strobe with read and write idle selects program memory everywhere.
// - Data read in the top region selects the nonvolatile memory for reading.
// - Without override only the lowest 512 bytes, up to E1FF, accept writes.
// - Address bits nine to twelve gate the nonvolatile-memory write output.
// - Grounding the full-write enable line opens every nonvolatile location to writes.
// - Every decoded device strobe is active only while write is asserted.
// - A write to 0000 hex loads the keypad holding register.
// - A write to 2000 hex loads the I/O-board holding register.
// - Regions 4000 through C000 drive the five peripheral write strobes.
// - Data sits on bus bits zero to seven before the strobe clocks it in.
// - Holding registers capture data on the strobe's rising edge, else hold.
// - The keypad holding register is eight bits wide driving LEDs, display, scan.
// - An unserviced watchdog emits a 200 millisecond reset pulse.
// - Watchdog service comes from bit zero of the I/O-board holding register.
// - Processor reset is watchdog pulse ORed with inverted power-on reset and the boot-detect pulse.
// - Panel driver power follows the backlight drive bit.
// - A high programming-voltage detect puts the processor into boot mode.
// - Every detect transition gives a processor reset pulse of at least 5 microseconds.
`timescale 1ns/1ps
`default_nettype none
`include "bdr_consts.vh"

module bdr_board_glue #(
  parameter [31:0] WDG_TIMEOUT_CYC = `BDR_WDG_TIMEOUT_CYC,
  parameter [31:0] WDG_PULSE_CYC = `BDR_WDG_PULSE_CYC
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Processor external bus, active-low strobes.
  input wire [15:0] busAddr,
  input wire [7:0] busData,
  input wire programFetchStrobe_n,
  input wire readStrobe_n,
  input wire writeStrobe_n,
  // Board straps and supervisory inputs.
  input wire full_nvm_write_enable_n,
  input wire powerOnReset_n,
  input wire boot_voltage_detect,
  // Memory selects, active low.
  output wire programMemSelect_n,
  output wire nvmReadSelect_n,
  output wire nvmWriteStrobe_n,
  // Peripheral board write strobes, active low.
  output wire [4:0] peripheralStrobe_n,
  // Holding register outputs.
  output reg [7:0] keypadLatch,
  output reg [7:0] ioLatch,
  output wire backlight_drive,
  // Processor reset and mode.
  output wire processorReset,
  output wire bootMode
);

  // Synchronised bus and pin inputs.
  reg [15:0] addrMeta_q;
  reg [15:0] addr_q;
  reg [7:0] dataMeta_q;
  reg [7:0] data_q;
  reg [2:0] strbMeta_q;
  reg [2:0] strb_q;
  reg [2:0] pinMeta_q;
  reg [2:0] pin_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrMeta_q <= 16'h0000;
      addr_q <= 16'h0000;
      dataMeta_q <= 8'h00;
      data_q <= 8'h00;
      strbMeta_q <= 3'h7;
      strb_q <= 3'h7;
      pinMeta_q <= 3'h3;
      pin_q <= 3'h3;
    end else begin
      addrMeta_q <= busAddr;
      addr_q <= addrMeta_q;
      dataMeta_q <= busData;
      data_q <= dataMeta_q;
      strbMeta_q <= {programFetchStrobe_n, readStrobe_n, writeStrobe_n};
      strb_q <= strbMeta_q;
      pinMeta_q <= {boot_voltage_detect, powerOnReset_n, full_nvm_write_enable_n};
      pin_q <= pinMeta_q;
    end
  end

  wire fetchAct = ~strb_q[2];
  wire readAct = ~strb_q[1];
  wire writeAct = ~strb_q[0];
  wire fullWrite = ~pin_q[0];
  wire porActive = ~pin_q[1];
  wire bootDetect = pin_q[2];
  wire [2:0] region = addr_q[15:13];

  // Decode outputs, one per region, gated by write.
  wire [7:0] decodeOut;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gDecode
      assign decodeOut[g] = writeAct & (region == g);
    end
  endgenerate

  assign programMemSelect_n = ~(fetchAct & ~readAct & ~writeAct);
  assign nvmReadSelect_n = ~(readAct & ~fetchAct & (region == `BDR_REGION_NVM));

  // The protect gate is open when bits nine to twelve are all zero or full write is enabled.
  wire protectGate = (addr_q[12:9] == `BDR_NVM_OPEN_BLOCK) | fullWrite;
  assign nvmWriteStrobe_n = ~(decodeOut[`BDR_REGION_NVM] & protectGate);

  assign peripheralStrobe_n = ~decodeOut[`BDR_REGION_PERIPH5:`BDR_REGION_PERIPH1];

  // Holding registers load on the rising edge of the released strobe, as the strobe's
  // trailing edge is where the data is certainly settled on the bus.
  reg [7:0] decodeOut_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decodeOut_q <= 8'h00;
    end else begin
      decodeOut_q <= decodeOut;
    end
  end

  wire keypadLoad = decodeOut_q[`BDR_REGION_KEYPAD] & ~decodeOut[`BDR_REGION_KEYPAD];
  wire ioLoad = decodeOut_q[`BDR_REGION_IO] & ~decodeOut[`BDR_REGION_IO];
  reg [7:0] dataHold_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataHold_q <= 8'h00;
      keypadLatch <= 8'h00;
      ioLatch <= 8'h00;
    end else begin
      if (writeAct) begin
        dataHold_q <= data_q;
      end
      if (keypadLoad) begin
        keypadLatch <= dataHold_q;
      end
      if (ioLoad) begin
        ioLatch <= dataHold_q;
      end
    end
  end

  assign backlight_drive = ioLatch[`BDR_WDG_LATCH_BIT];

  // Watchdog: any edge of the service bit restarts the timeout.
  wire watchdog_service_input = ioLatch[`BDR_WDG_LATCH_BIT];
  reg serviceLast_q;
  reg [31:0] wdgCount_q;
  reg [31:0] wdgPulse_q;
  wire serviced = watchdog_service_input ^ serviceLast_q;
  wire wdgPulse = (wdgPulse_q != 32'h0000_0000);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serviceLast_q <= 1'b0;
      wdgCount_q <= 32'h0000_0000;
      wdgPulse_q <= 32'h0000_0000;
    end else begin
      serviceLast_q <= watchdog_service_input;
      if (wdgPulse) begin
        wdgPulse_q <= wdgPulse_q - 32'h0000_0001;
        wdgCount_q <= 32'h0000_0000;
      end else if (serviced || porActive) begin
        wdgCount_q <= 32'h0000_0000;
      end else if (wdgCount_q >= WDG_TIMEOUT_CYC - 32'h0000_0001) begin
        wdgCount_q <= 32'h0000_0000;
        wdgPulse_q <= WDG_PULSE_CYC;
      end else begin
        wdgCount_q <= wdgCount_q + 32'h0000_0001;
      end
    end
  end

  // Boot mode and the reset pulse on each detect transition.
  reg bootLast_q;
  // Kept as wide as the constant so the reload value is never cut short.
  reg [31:0] bootPulse_q;
  wire bootPulse = (bootPulse_q != 32'h0000_0000);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bootLast_q <= 1'b0;
      bootPulse_q <= 32'h0000_0000;
    end else begin
      bootLast_q <= bootDetect;
      if (bootDetect != bootLast_q) begin
        bootPulse_q <= `BDR_BOOT_PULSE_CYC;
      end else if (bootPulse) begin
        bootPulse_q <= bootPulse_q - 32'h0000_0001;
      end
    end
  end

  assign bootMode = bootLast_q;
  assign processorReset = wdgPulse | porActive | bootPulse;

endmodule // bdr_board_glue
`default_nettype wire

// ### bdr_consts.vh
// Constants for the board address decode and reset glue block.
`ifndef BDR_CONSTS_VH
`define BDR_CONSTS_VH
`define BDR_KEYPAD_LATCH_ADDR 16'h0000
`define BDR_IO_LATCH_ADDR 16'h2000
`define BDR_REGION_KEYPAD 3'h0
`define BDR_REGION_IO 3'h1
`define BDR_REGION_PERIPH1 3'h2
`define BDR_REGION_PERIPH2 3'h3
`define BDR_REGION_PERIPH3 3'h4
`define BDR_REGION_PERIPH4 3'h5
`define BDR_REGION_PERIPH5 3'h6
`define BDR_REGION_NVM 3'h7
`define BDR_NVM_OPEN_BLOCK 4'h0
`define BDR_WDG_LATCH_BIT 0
`define BDR_CLK_NS 4
`define BDR_WDG_TIMEOUT_MS 1600
`define BDR_WDG_PULSE_MS 200
`define BDR_BOOT_PULSE_US 5
`define BDR_WDG_TIMEOUT_CYC (`BDR_WDG_TIMEOUT_MS * 1000000 / `BDR_CLK_NS)
`define BDR_WDG_PULSE_CYC (`BDR_WDG_PULSE_MS * 1000000 / `BDR_CLK_NS)
`define BDR_BOOT_PULSE_CYC ((`BDR_BOOT_PULSE_US * 1000 + `BDR_CLK_NS - 1) / `BDR_CLK_NS)
`endif

// ### bdr_board_glue_chk.sv
// Checker for decode, holding-register and reset glue.
`timescale 1ns/1ps
`default_nettype none
module bdr_board_glue_chk (
  // Clock, reset, bus and straps.
  input wire logic clk, resetn, programFetchStrobe_n, readStrobe_n, writeStrobe_n, boot_voltage_detect,
  input wire logic full_nvm_write_enable_n,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busData, ioLatch,
  // Outputs.
  input wire logic programMemSelect_n, nvmReadSelect_n, nvmWriteStrobe_n, backlight_drive, processorReset,
  input wire logic [4:0] peripheralStrobe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [2:0] rg = busAddr[15:13];
  // Pins reach the outputs two edges late, so expectations come from the pins.
  wire logic [4:0] pw = !writeStrobe_n && rg > 3'h1 && rg < 3'h7 ? 5'h01 << (rg - 3'h2) : 5'h00;
  wire logic nw = !writeStrobe_n && rg == 3'h7 && (busAddr[12:9] == 4'h0 || !full_nvm_write_enable_n);
  fetch_sel_a: assert property (programMemSelect_n == $past(programFetchStrobe_n, 2)) else $error("fetch");
  nvm_read_a: assert property (nvmReadSelect_n == $past(readStrobe_n || rg != 3'h7, 2))
    else $error("nvm read");
  nvm_write_a: assert property (!nvmWriteStrobe_n == $past(nw, 2)) else $error("nvm write");
  periph_strobe_a: assert property (~peripheralStrobe_n == $past(pw, 2)) else $error("strobe");
  io_load_a: assert property ($rose(writeStrobe_n) && $past(rg) == 3'h1
    |-> ##[3:4] ioLatch == $past(busData, 4)) else $error("io load");
  io_hold_a: assert property ($past(writeStrobe_n, 4) && $past(writeStrobe_n, 5) |-> $stable(ioLatch))
    else $error("io hold");
  light_a: assert property (backlight_drive == ioLatch[0]) else $error("backlight");
  boot_pulse_a: assert property ($changed(boot_voltage_detect) |-> ##[2:3] processorReset [*8])
    else $error("boot pulse");
  cover property ($rose(ioLatch[0]));
  cover property (!nvmWriteStrobe_n && busAddr[12:9] != 4'h0);
  cover property ($fell(peripheralStrobe_n[4]));
endmodule // bdr_board_glue_chk
`default_nettype wire

// ### bdr_bus_model.sv
// Processor bus model running fetch, read and write cycles.
`timescale 1ns/1ps
`default_nettype none
module bdr_bus_model (
  // Clock in; address, byte and strobes (fetch, read, write) out.
  input wire logic clk,
  output logic [15:0] busAddr,
  output logic [7:0] busData,
  output logic [2:0] strobe_n
);
  initial {busAddr, busData, strobe_n} = 27'h000_0007;
  // The byte leads the strobe and outlives it; a released bus shows junk.
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input int k);
    busAddr <= a;
    busData <= d;
    @(posedge clk);
    strobe_n[k] <= 1'b0;
    repeat (2) @(posedge clk);
    strobe_n <= 3'h7;
    repeat (3) @(posedge clk);
    busData <= ~d;
    @(posedge clk);
  endtask
endmodule // bdr_bus_model
`default_nettype wire

// ### bdr_board_glue_test.sv
// Self-checking bench for the board glue block.
`timescale 1ns/1ps
`default_nettype none
module bdr_board_glue_test;
  logic clk = 1'b0, resetn = 1'b0, powerOnReset_n = 1'b1, boot_voltage_detect = 1'b0;
  logic full_nvm_write_enable_n = 1'b1, programMemSelect_n, nvmReadSelect_n, nvmWriteStrobe_n;
  logic backlight_drive, processorReset, bootMode;
  logic [15:0] busAddr, ad, corner [5] = '{16'h0000, 16'h2000, 16'he1ff, 16'he200, 16'hffff};
  logic [7:0] busData, keypadLatch, ioLatch, seen, x, kExp = 8'h00, iExp = 8'h01;
  logic [4:0] peripheralStrobe_n;
  logic [2:0] s;
  int err_total = 0, samples_checked = 0, i, k, n;
  wire logic programFetchStrobe_n = s[0], readStrobe_n = s[1], writeStrobe_n = s[2];
  bdr_bus_model bdr_bus_model_i (.clk, .busAddr, .busData, .strobe_n(s));
  bdr_board_glue #(.WDG_TIMEOUT_CYC(32'h0000_0bb8), .WDG_PULSE_CYC(32'h0000_0032)) bdr_board_glue_i (.*);
  initial forever #2 clk = ~clk;
  always @(posedge clk) seen <= seen | ~{programMemSelect_n, nvmReadSelect_n, nvmWriteStrobe_n, peripheralStrobe_n};
  function automatic logic [7:0] want(logic [15:0] a, int kk, logic e);
    logic [2:0] r;
    r = a[15:13];
    want = {kk == 0, kk == 1 && r == 3'h7, kk == 2 && r == 3'h7 && (a[12:9] == 4'h0 || !e), 5'h00};
    if (kk == 2 && r > 3'h1 && r < 3'h7) want[r - 3'h2] = 1'b1;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) $display("BAD %0t %h %h", $time, got, exp);
    if (got !== exp) err_total++;
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bounded wait for a reset pulse, then its length in cycles.
  task automatic pulse;
    for (i = 0; i < 4000 && processorReset !== 1'b1; i++) @(negedge clk);
    for (n = 0; processorReset === 1'b1 && n < 3000; n++) @(negedge clk);
    if (i >= 4000 || n >= 3000) err_total++;
  endtask
  initial begin
    i = $urandom(32'h4da4_7b81);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    for (k = 1; k >= 0; k--) begin
      boot_voltage_detect <= k[0];
      pulse;
      chk(16'(n >= 1250 && n < 3000), 16'h0001);
      chk(16'(bootMode), 16'(k));
      @(posedge clk);
    end
    powerOnReset_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(processorReset), 16'h0001);
    @(posedge clk);
    powerOnReset_n <= 1'b1;
    // One service toggle and then silence, so the watchdog must expire.
    bdr_bus_model_i.cyc(16'h2000, 8'h01, 2);
    pulse;
    chk(16'(n), 16'h0032);
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      seen = 8'h00;
      @(posedge clk);
      ad = k < 5 ? corner[k] : 16'($urandom);
      n = k < 5 ? 2 : $urandom_range(2, 0);
      x = 8'($urandom);
      full_nvm_write_enable_n <= k < 5 ? 1'b1 : 1'($urandom);
      bdr_bus_model_i.cyc(ad, x, n);
      @(negedge clk);
      chk({8'h00, seen}, {8'h00, want(ad, n, full_nvm_write_enable_n)});
      kExp = n == 2 && ad[15:13] == 3'h0 ? x : kExp;
      iExp = n == 2 && ad[15:13] == 3'h1 ? x : iExp;
      chk({keypadLatch, ioLatch}, {kExp, iExp});
    end
    tally_and_finish;
  end
endmodule // bdr_board_glue_test
bind bdr_board_glue bdr_board_glue_chk bdr_board_glue_chk_i (.*);
`default_nettype wire
